//--- base_address_bank.sv
// three configuration base address registers with card-mode strap latch
// Behaviour
// R1 - host window base stores bits 31..11 and reads them back
// R2 - all ones written to host base reads back as FFFFF800
// R3 - host base bits 10..4 read zero, 2-Kbyte window
// R4 - host base bit 3 reads zero, nonprefetchable
// R5 - host base bits 2..1 read zero, 32-bit placement anywhere
// R6 - host base bit 0 reads zero, memory space
// R7 - extension base at 14h behaves like the host base
// R8 - strap high at reset: card base reads zero, ignores writes
// R9 - strap low at reset: card base bits 31..11 writable
// R10 - host must write nonzero card base before using that window
// R11 - card base bits 10..4 read zero, 2-Kbyte window
// R12 - host reads card structure window only with byte accesses
// R13 - card base bits 3, 2..1 and 0 read zero
// R14 - strap level sampled at reset selects card mode
// R15 - sampled strap held until next reset
// R16 - reset clears all bases; writes touch only pointer bits per byte
`timescale 1ns/1ps
`default_nettype none
`include "bar_cfg.svh"

module base_address_bank (
	// clock and reset
	input  wire logic             clk_in,
	input  wire logic             nrst_in,
	// configuration access
	input  wire bar_pkg::cfg_req_t cfg_req_in,
	output var  bar_pkg::cfg_rsp_t cfg_rsp_out,
	// strap pin
	input  wire logic             card_mode_strap_in,
	// window bases for the address decoders
	output logic      [31:0]      host_window_base_out,
	output logic      [31:0]      ext_window_base_out,
	output logic      [31:0]      card_struct_base_out,
	output logic                  card_struct_enable_out
);
	import bar_pkg::*;

	bank_state_t state_reg;
	bank_state_t state_next;
	logic [20:0] host_ptr;
	logic [20:0] ext_ptr;
	logic [20:0] card_ptr;
	logic        card_en;
	logic [31:0] rd_word;
	logic        rd_hit;

	function automatic logic hits(input logic [7:0] addr, input logic [7:0] ofs);
		hits = (addr == ofs);
	endfunction

	function automatic logic mapped(input logic [7:0] addr);
		mapped = hits(addr, `BAR_HOST_OFS) || hits(addr, `BAR_EXT_OFS)
			|| hits(addr, `BAR_CARD_OFS);
	endfunction

	// attribute bits are hard zero: memory, 32-bit, nonprefetchable, 2 Kbyte
	function automatic logic [31:0] bar_word(input logic [20:0] ptr);
		bar_word = {ptr, `BAR_ATTR_BITS}; // R2
	endfunction

	// card base stays dead until the strap has been latched low
	assign card_en = state_reg.sampled && !state_reg.strap; // R14

	window_base_reg u_host (
		.clk_in    (clk_in),
		.nrst_in   (nrst_in),
		.wr_in     (cfg_req_in.wr && hits(cfg_req_in.addr, `BAR_HOST_OFS)), // R1
		.be_in     (cfg_req_in.be),
		.wdata_in  (cfg_req_in.wdata),
		.enable_in (1'b1),
		.ptr_out   (host_ptr)
	);

	window_base_reg u_ext (
		.clk_in    (clk_in),
		.nrst_in   (nrst_in),
		.wr_in     (cfg_req_in.wr && hits(cfg_req_in.addr, `BAR_EXT_OFS)), // R7
		.be_in     (cfg_req_in.be),
		.wdata_in  (cfg_req_in.wdata),
		.enable_in (1'b1),
		.ptr_out   (ext_ptr)
	);

	window_base_reg u_card (
		.clk_in    (clk_in),
		.nrst_in   (nrst_in),
		.wr_in     (cfg_req_in.wr && hits(cfg_req_in.addr, `BAR_CARD_OFS)), // R9
		.be_in     (cfg_req_in.be),
		.wdata_in  (cfg_req_in.wdata),
		.enable_in (card_en), // R8
		.ptr_out   (card_ptr)
	);

	always_comb begin
		rd_word = `BAR_WORD_ZERO;
		rd_hit  = 1'b1;
		// a same-cycle write lands after this answer is formed
		if (hits(cfg_req_in.addr, `BAR_HOST_OFS)) begin
			rd_word = bar_word(host_ptr); // R3 R4 R5 R6
		end else if (hits(cfg_req_in.addr, `BAR_EXT_OFS)) begin
			rd_word = bar_word(ext_ptr); // R7
		end else if (hits(cfg_req_in.addr, `BAR_CARD_OFS)) begin
			rd_word = card_en ? bar_word(card_ptr) : `BAR_WORD_ZERO; // R8 R11 R13
		end else begin
			rd_hit = 1'b0;
		end
	end

	always_comb begin
		state_next = state_reg;
		// only the second stage is read; the first may still be settling
		state_next.sync1 = card_mode_strap_in;
		state_next.sync2 = state_reg.sync1;
		// wait for the synchroniser to fill before trusting the strap
		if (!state_reg.sampled) begin
			if (state_reg.wait_cnt == `BAR_STRAP_WAIT) begin
				state_next.sampled = 1'b1; // R14
				state_next.strap   = state_reg.sync2; // R14
			end else begin
				state_next.wait_cnt = state_reg.wait_cnt + 2'h1;
			end
		end
		state_next.rsp.ack   = cfg_req_in.rd;
		state_next.rsp.hit   = cfg_req_in.rd && rd_hit;
		state_next.rsp.rdata = cfg_req_in.rd ? rd_word : `BAR_WORD_ZERO; // R1
	end

	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			state_reg.sync1    <= 1'b0;
			state_reg.sync2    <= 1'b0;
			state_reg.wait_cnt <= 2'h0;
			state_reg.sampled  <= 1'b0;
			state_reg.strap    <= 1'b1;
			state_reg.rsp      <= '0;
		end else begin
			state_reg <= state_next; // R15
		end
	end

	// decoders see the bases straight from the pointer flops
	assign cfg_rsp_out            = state_reg.rsp;
	assign host_window_base_out   = bar_word(host_ptr);
	assign ext_window_base_out    = bar_word(ext_ptr);
	assign card_struct_base_out   = card_en ? bar_word(card_ptr) : `BAR_WORD_ZERO;
	assign card_struct_enable_out = card_en;

	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!nrst_in);

	a_read_ack: assert property (cfg_req_in.rd |=> cfg_rsp_out.ack) // R1
		else $error("read not acknowledged next cycle");
	a_sizing_read: assert property ((cfg_req_in.wr && !cfg_req_in.rd // R2
		&& hits(cfg_req_in.addr, `BAR_HOST_OFS) && cfg_req_in.be == `BAR_BE_ALL
		&& cfg_req_in.wdata == `BAR_ALL_ONES)
		##1 (cfg_req_in.rd && !cfg_req_in.wr && hits(cfg_req_in.addr, `BAR_HOST_OFS))
		|=> cfg_rsp_out.rdata == `BAR_SIZING_READ)
		else $error("sizing readback wrong");
	a_attr_zero: assert property (cfg_rsp_out.ack // R3 R4 R5 R6 R11 R13
		|-> cfg_rsp_out.rdata[`BAR_ATTR_W-1:0] == `BAR_ATTR_BITS)
		else $error("attribute bits not zero");
	a_ext_write: assert property (cfg_req_in.wr && hits(cfg_req_in.addr, `BAR_EXT_OFS) // R7
		&& cfg_req_in.be == `BAR_BE_ALL
		|=> ext_window_base_out == {$past(cfg_req_in.wdata[31:11]), `BAR_ATTR_BITS})
		else $error("extension base write lost");
	a_card_off: assert property (cfg_req_in.rd && hits(cfg_req_in.addr, `BAR_CARD_OFS) // R8
		&& !card_en |=> cfg_rsp_out.rdata == `BAR_WORD_ZERO)
		else $error("card base readable while strap high");
	a_card_write: assert property (card_en && cfg_req_in.wr // R9
		&& hits(cfg_req_in.addr, `BAR_CARD_OFS) && cfg_req_in.be == `BAR_BE_ALL
		|=> card_struct_base_out[31:11] == $past(cfg_req_in.wdata[31:11]))
		else $error("card base write lost");
	a_strap_hold: assert property (state_reg.sampled // R15
		|=> state_reg.sampled && $stable(state_reg.strap))
		else $error("latched strap changed");
	a_strap_time: assert property ($rose(nrst_in) |-> ##3 state_reg.sampled) // R14
		else $error("strap not latched in time");

	// read path: answer one cycle later, old value on a same-cycle write
	a_idle_quiet: assert property (!cfg_req_in.rd // R1
		|=> !cfg_rsp_out.ack && !cfg_rsp_out.hit && cfg_rsp_out.rdata == `BAR_WORD_ZERO)
		else $error("answer without a read");
	a_host_read: assert property (cfg_req_in.rd && hits(cfg_req_in.addr, `BAR_HOST_OFS) // R1
		|=> cfg_rsp_out.rdata == $past(host_window_base_out))
		else $error("host base read wrong");
	a_ext_read: assert property (cfg_req_in.rd && hits(cfg_req_in.addr, `BAR_EXT_OFS) // R7
		|=> cfg_rsp_out.rdata == $past(ext_window_base_out))
		else $error("extension base read wrong");
	a_card_read: assert property (cfg_req_in.rd && hits(cfg_req_in.addr, `BAR_CARD_OFS) // R9
		|=> cfg_rsp_out.rdata == $past(card_struct_base_out))
		else $error("card base read wrong");
	a_hit_mapped: assert property (cfg_req_in.rd && mapped(cfg_req_in.addr) // R7
		|=> cfg_rsp_out.hit)
		else $error("mapped offset not flagged");
	a_unmapped_zero: assert property (cfg_req_in.rd && !mapped(cfg_req_in.addr) // R1
		|=> !cfg_rsp_out.hit && cfg_rsp_out.rdata == `BAR_WORD_ZERO)
		else $error("unmapped offset answered with data");

	// write path: only the pointer bits move
	a_host_write: assert property (cfg_req_in.wr && hits(cfg_req_in.addr, `BAR_HOST_OFS) // R1
		&& cfg_req_in.be == `BAR_BE_ALL
		|=> host_window_base_out[31:`BAR_PTR_LSB]
			== $past(cfg_req_in.wdata[31:`BAR_PTR_LSB]))
		else $error("host base write lost");
	a_card_shut: assert property (!card_en && cfg_req_in.wr // R8
		&& hits(cfg_req_in.addr, `BAR_CARD_OFS) |=> card_struct_base_out == `BAR_WORD_ZERO)
		else $error("card base took a write while shut");

	// strap latch: captured once from the second synchroniser stage
	a_strap_capture: assert property ($rose(state_reg.sampled) // R14
		|-> state_reg.strap == $past(state_reg.sync2))
		else $error("strap latched from wrong stage");
	a_wait_bound: assert property (state_reg.wait_cnt <= `BAR_STRAP_WAIT) // R14
		else $error("strap wait counter overran");
	a_enable_hold: assert property (card_struct_enable_out |=> card_struct_enable_out) // R15
		else $error("card mode dropped before reset");

endmodule // base_address_bank

`default_nettype wire

//--- bar_cfg.svh
// constants for the configuration base address register bank
`ifndef BAR_CFG_SVH
`define BAR_CFG_SVH

`define BAR_HOST_OFS     8'h10
`define BAR_EXT_OFS      8'h14
`define BAR_CARD_OFS     8'h18
`define BAR_PTR_LSB      11
`define BAR_PTR_W        21
`define BAR_ATTR_W       11
`define BAR_PTR_RESET    21'h000000
`define BAR_ATTR_BITS    11'h000
`define BAR_SIZING_READ  32'hFFFFF800
`define BAR_ALL_ONES     32'hFFFFFFFF
`define BAR_BE_ALL       4'hF
`define BAR_STRAP_WAIT   2'h2
`define BAR_WORD_ZERO    32'h00000000

`endif

//--- bar_pkg.sv
// types shared by the base address register bank
`default_nettype none
package bar_pkg;

	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [7:0]  addr;
		logic [3:0]  be;
		logic [31:0] wdata;
	} cfg_req_t;

	typedef struct packed {
		logic        ack;
		logic        hit;
		logic [31:0] rdata;
	} cfg_rsp_t;

	typedef struct packed {
		logic [20:0] ptr;
	} bar_state_t;

	typedef struct packed {
		logic        sync1;
		logic        sync2;
		logic [1:0]  wait_cnt;
		logic        sampled;
		logic        strap;
		cfg_rsp_t    rsp;
	} bank_state_t;

endpackage

`default_nettype wire

//--- window_base_reg.sv
// one base register: writable pointer bits 31..11, byte enables honoured
`timescale 1ns/1ps
`default_nettype none
`include "bar_cfg.svh"

module window_base_reg (
	// clock and reset
	input  wire logic        clk_in,
	input  wire logic        nrst_in,
	// write port
	input  wire logic        wr_in,
	input  wire logic [3:0]  be_in,
	input  wire logic [31:0] wdata_in,
	input  wire logic        enable_in,
	// stored pointer
	output logic      [20:0] ptr_out
);
	import bar_pkg::*;

	bar_state_t state_reg;
	bar_state_t state_next;
	logic [20:0] lane_mask;

	genvar i;
	generate
		for (i = 0; i < `BAR_PTR_W; i++) begin : g_lane
			assign lane_mask[i] = be_in[(i + `BAR_PTR_LSB) / 8]; // R16
		end
	endgenerate

	always_comb begin
		state_next = state_reg;
		if (!enable_in) begin
			state_next.ptr = `BAR_PTR_RESET; // R8
		end else if (wr_in) begin
			state_next.ptr = (wdata_in[31:`BAR_PTR_LSB] & lane_mask) // R1 R9
				| (state_reg.ptr & ~lane_mask); // R16
		end
	end

	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			state_reg.ptr <= `BAR_PTR_RESET; // R16
		end else begin
			state_reg <= state_next;
		end
	end

	assign ptr_out = state_reg.ptr;

	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!nrst_in);

	a_lane_untouched: assert property (wr_in && enable_in && !be_in[3] // R16
		|=> ptr_out[20:13] == $past(ptr_out[20:13]))
		else $error("upper byte changed without its byte enable");
	a_idle_stable: assert property (!wr_in && enable_in && $past(enable_in) // R1
		|=> ptr_out == $past(ptr_out))
		else $error("pointer changed without a write");
	a_disabled_zero: assert property (!enable_in |=> ptr_out == `BAR_PTR_RESET) // R8
		else $error("disabled pointer not zero");

endmodule // window_base_reg

`default_nettype wire

//--- host_model.sv
// configuration master model standing in for the host bridge
`timescale 1ns/1ps
`default_nettype none

module host_model (
	// clock
	input  wire logic              clk_in,
	// configuration bus
	output var  bar_pkg::cfg_req_t req_out,
	input  wire bar_pkg::cfg_rsp_t rsp_in
);
	import bar_pkg::*;

	initial req_out = '0;

	// one-cycle write strobe, data scrambled once released
	task automatic cfg_write(input logic [7:0] a, input logic [3:0] b, input logic [31:0] d);
		@(negedge clk_in);
		req_out = '{wr: 1'b1, rd: 1'b0, addr: a, be: b, wdata: d};
		@(negedge clk_in);
		req_out.wr = 1'b0;
		req_out.wdata = ~d;
	endtask

	// write then read at once, the back-to-back case of a sizing probe
	task automatic cfg_write_read(input logic [7:0] a, input logic [3:0] b,
		input logic [31:0] d, output cfg_rsp_t r);
		@(negedge clk_in);
		req_out = '{wr: 1'b1, rd: 1'b0, addr: a, be: b, wdata: d};
		@(negedge clk_in);
		req_out.wr = 1'b0;
		req_out.rd = 1'b1;
		@(negedge clk_in);
		r = rsp_in;
		req_out.rd = 1'b0;
	endtask

	// config cycles only: no card window reads, so none wider than a byte
	// answer is registered at the taking edge, so seen one half cycle later
	task automatic cfg_read(input logic [7:0] a, output cfg_rsp_t r);
		@(negedge clk_in);
		req_out.addr = a;
		req_out.rd = 1'b1;
		@(negedge clk_in);
		r = rsp_in;
		req_out.rd = 1'b0;
	endtask
endmodule // host_model
`default_nettype wire

//--- tb.sv
// self-checking bench for the base address register bank
`timescale 1ns/1ps
`default_nettype none

module tb;
	import bar_pkg::*;
	logic        clk;
	logic        nrst;
	logic        strap;
	cfg_req_t    req;
	cfg_rsp_t    rsp;
	cfg_rsp_t    r;
	logic [31:0] host_base;
	logic [31:0] ext_base;
	logic [31:0] card_base;
	logic        card_en;
	int          bad_count = 0;
	int          total_checks = 0;

	base_address_bank DUT (.clk_in(clk), .nrst_in(nrst), .cfg_req_in(req), .cfg_rsp_out(rsp),
		.card_mode_strap_in(strap), .host_window_base_out(host_base),
		.ext_window_base_out(ext_base), .card_struct_base_out(card_base),
		.card_struct_enable_out(card_en));
	host_model host (.clk_in(clk), .req_out(req), .rsp_in(rsp));

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	task automatic finish_test;
		$display("checks=%0d mismatches=%0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic hit);
		host.cfg_read(a, r);
		chk({30'h0, r.ack, r.hit}, {30'h0, 1'b1, hit});
		chk(r.rdata, exp);
	endtask

	// strap settles during reset; four edges let the latch fill
	task automatic do_reset(input logic s);
		nrst = 1'b0;
		strap = s;
		repeat (3) @(negedge clk);
		nrst = 1'b1;
		repeat (4) @(negedge clk);
	endtask

	initial begin
		#20000;
		bad_count++;
		finish_test;
	end

	initial begin
		do_reset(1'b1);
		rd_chk(8'h10, 32'h00000000, 1'b1);
		rd_chk(8'h14, 32'h00000000, 1'b1);
		rd_chk(8'h1C, 32'h00000000, 1'b0);
		host.cfg_write_read(8'h10, 4'hF, 32'hFFFFFFFF, r);
		chk({30'h0, r.ack, r.hit}, {30'h0, 1'b1, 1'b1});
		chk(r.rdata, 32'hFFFFF800);
		rd_chk(8'h10, 32'hFFFFF800, 1'b1);
		chk(host_base, 32'hFFFFF800);
		host.cfg_write(8'h10, 4'h2, 32'h12345678);
		rd_chk(8'h10, 32'hFFFF5000, 1'b1);
		host.cfg_write(8'h14, 4'hC, 32'hA5A5FFFF);
		rd_chk(8'h14, 32'hA5A50000, 1'b1);
		chk(ext_base, 32'hA5A50000);
		host.cfg_write(8'h14, 4'hF, 32'h1234FFFF);
		rd_chk(8'h14, 32'h1234F800, 1'b1);
		chk(ext_base, 32'h1234F800);
		host.cfg_write(8'h18, 4'hF, 32'hFFFFFFFF);
		rd_chk(8'h18, 32'h00000000, 1'b1);
		chk(card_base, 32'h00000000);
		// late strap change must not open the card base
		strap = 1'b0;
		repeat (4) @(negedge clk);
		host.cfg_write(8'h18, 4'hF, 32'hFFFFFFFF);
		rd_chk(8'h18, 32'h00000000, 1'b1);
		chk({31'h0, card_en}, 32'h00000000);
		do_reset(1'b0);
		rd_chk(8'h10, 32'h00000000, 1'b1);
		chk({31'h0, card_en}, 32'h00000001);
		rd_chk(8'h14, 32'h00000000, 1'b1);
		chk(ext_base, 32'h00000000);
		host.cfg_write(8'h18, 4'hF, 32'hFFFFFFFF);
		rd_chk(8'h18, 32'hFFFFF800, 1'b1);
		chk(card_base, 32'hFFFFF800);
		strap = 1'b1;
		repeat (4) @(negedge clk);
		chk({31'h0, card_en}, 32'h00000001);
		finish_test;
	end
endmodule // tb
`default_nettype wire
